// file: bridge_sideband_regs.svh
`ifndef BRIDGE_SIDEBAND_REGS_SVH
`define BRIDGE_SIDEBAND_REGS_SVH
// Register byte offsets
`define REG_CTRL_OFF 12'h000
`define REG_STATUS_OFF 12'h004
`define REG_SAMPLE_OFF 12'h008
`define REG_ROMLO_OFF 12'h00C
`define REG_ROMHI_OFF 12'h010
// Control field positions
`define CTRL_ROM_REMOTE_BIT 0
`define CTRL_NMI_CLR_BIT 1
`define CTRL_WLOCK_BIT 2
// Status field positions
`define STAT_NMI_BIT 0
`define STAT_PAR_BIT 1
`define STAT_IRQ_BIT 2
`define STAT_WLOCK_BIT 3
`define STAT_ROMFULL_BIT 4
`define STAT_STRAP_BIT 5
// Reset values
`define CTRL_RESET 32'h0000_0000
// Low memory window: 16M
`define LOW_MEM_MASK 32'h00FF_FFFF
// ROM bytes per assembled word
`define ROM_BYTES 8
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: bridge_sideband_pkg.sv
package bridge_sideband_pkg;
	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_SAMPLE = 3'b010,
		RD_ECC_HOLD = 3'b100
	} rd_state_e;
endpackage

// file: bridge_sideband_and_datapath_ctl.sv
// Overview of operation
// - Ignore-high-addr in address phase: drop top eight bits, map below 16M.
// - Resync interrupt request, then drive active-low processor interrupt.
// - Detected non-maskable request reports an error to the processor.
// - Power-on reset inits latches, resamples strap, clears ROM lockout.
// - ROM strobes serve direct ROM only; both stay high for remote ROM.
// - Bad processor data parity on a write asserts the parity fault output.
// - All-ones select forces all 64 data lines to one, except during ROM byte load.
// - During ROM byte load, shared select tells direct or remote ROM.
// - PCI burst read: mask up after first sample until latch empty.
// - Write latch captures every clock while open, holds otherwise.
// - Data output enable asserted: drive processor data one clock later.
// - Read latch loads each clock while open; opened for memory or PCI.
// - Memory sample keeps read latch open one more clock for ECC.
// - Read latch open must not fall before memory read sample falls.
// - Sample strobe times ECC check, loads PCI extension and read latches.
// - ROM byte load gathers eight bytes, then delivers them to processor.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_sideband_regs.svh"

module bridge_sideband_and_datapath_ctl #(
	parameter int DATA_W = 64,
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Power-on reset and clocking strap
	input wire logic power_on_reset_n,
	input wire logic clock_mode_strap,
	// PCI address remap
	input wire logic ignore_high_addr_bit,
	input wire logic pci_addr_phase,
	input wire logic [ADDR_W-1:0] pci_addr_in,
	output logic [ADDR_W-1:0] mem_addr_out,
	// Interrupts
	input wire logic irq_request_in,
	input wire logic nonmaskable_request_in,
	output logic proc_irq_out_n,
	output logic proc_error_out,
	// ROM
	input wire logic rom_read_req,
	input wire logic rom_write_req,
	input wire logic rom_byte_valid,
	input wire logic [7:0] rom_byte_in,
	output logic rom_oe_n,
	output logic rom_we_n,
	output logic [DATA_W-1:0] rom_word_out,
	output logic rom_word_valid,
	// Datapath control inputs
	input wire logic all_ones_req,
	input wire logic pci_burst_read,
	input wire logic pci_read_latch_empty,
	input wire logic mem_read_req,
	input wire logic pci_read_req,
	input wire logic proc_write_open_req,
	input wire logic proc_data_oe_n,
	// Processor data bus
	input wire logic [DATA_W-1:0] proc_data_in,
	input wire logic [7:0] proc_parity_in,
	input wire logic proc_write_cycle,
	output logic [DATA_W-1:0] proc_data_out,
	output logic proc_data_drive,
	// Memory data
	input wire logic [DATA_W-1:0] mem_data_in,
	// Strobes toward the data buffer
	output logic ones_romloc_mask_select,
	output logic read_sample_mask,
	output logic mem_read_sample,
	output logic proc_to_pci_wlatch_open,
	output logic proc_read_latch_open,
	output logic proc_bus_parity_fault_n,
	output logic [DATA_W-1:0] pci_read_latch_out,
	output logic [DATA_W-1:0] wlatch_out,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// Elaboration check: byte lanes and the 16M mask assume these widths
	if (DATA_W != 64 || ADDR_W < 25)
	begin : g_width_check
		$error("Unsupported width");
	end

	// Combined reset: bus reset or power-on reset both initialise latches
	logic rst_n;
	assign rst_n = aresetn & power_on_reset_n;

	// Register state
	logic [31:0] ctrl_ff;
	logic nmi_seen_ff;
	logic par_seen_ff;
	logic wlock_ff;
	logic strap_ff;
	logic rom_remote;
	assign rom_remote = ctrl_ff[`CTRL_ROM_REMOTE_BIT];

	// Two-stage synchronisers; stage one feeds only stage two
	logic [1:0] irq_sync_ff;
	logic [1:0] nmi_sync_ff;
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			irq_sync_ff <= 2'h0;
			nmi_sync_ff <= 2'h0;
		end
		else
		begin
			irq_sync_ff <= {irq_sync_ff[0], irq_request_in};
			nmi_sync_ff <= {nmi_sync_ff[0], nonmaskable_request_in};
		end
	end

	// Interrupt pass-through; the processor does its own masking
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			proc_irq_out_n <= 1'b1;
		else
			proc_irq_out_n <= ~irq_sync_ff[1];
	end

	// Error report stays up until software clears it; set wins over clear
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			nmi_seen_ff <= 1'b0;
		else if (nmi_sync_ff[1])
			nmi_seen_ff <= 1'b1;
		else if (ctrl_ff[`CTRL_NMI_CLR_BIT])
			nmi_seen_ff <= 1'b0;
	end
	assign proc_error_out = nmi_seen_ff;

	// Strap captured by a clocked process while power-on reset is held
	always_ff @(posedge aclk)
	begin
		if (!power_on_reset_n)
			strap_ff <= clock_mode_strap;
	end

	// Address remap for ISA masters; the sourcing side times the level
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			mem_addr_out <= '0;
		else if (pci_addr_phase)
		begin
			if (ignore_high_addr_bit)
				mem_addr_out <= pci_addr_in & ADDR_W'(`LOW_MEM_MASK);
			else
				mem_addr_out <= pci_addr_in;
		end
	end

	// ROM strobes; remote configuration keeps both high, lockout keeps only the write strobe high
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			rom_oe_n <= 1'b1;
			rom_we_n <= 1'b1;
		end
		else
		begin
			rom_oe_n <= rom_remote | ~rom_read_req;
			rom_we_n <= rom_remote | wlock_ff | ~rom_write_req;
		end
	end

	// Write lockout is set by software and only cleared by reset
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			wlock_ff <= 1'b0;
		else if (ctrl_ff[`CTRL_WLOCK_BIT])
			wlock_ff <= 1'b1;
	end

	// ROM byte gathering into an eight-byte word
	logic [2:0] rom_cnt_ff;
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			rom_cnt_ff <= 3'h0;
			rom_word_out <= '0;
			rom_word_valid <= 1'b0;
		end
		else
		begin
			rom_word_valid <= 1'b0;
			if (rom_byte_valid)
			begin
				rom_word_out[rom_cnt_ff*8 +: 8] <= rom_byte_in;
				rom_cnt_ff <= rom_cnt_ff + 3'h1;
				if (rom_cnt_ff == 3'(`ROM_BYTES - 1))
					rom_word_valid <= 1'b1;
			end
		end
	end

	// Read sample sequencer: sample, then one extra open cycle for ECC
	bridge_sideband_pkg::rd_state_e rd_state_ff;
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			rd_state_ff <= bridge_sideband_pkg::RD_IDLE;
		else
		begin
			unique case (rd_state_ff)
				bridge_sideband_pkg::RD_IDLE:
					if (mem_read_req)
						rd_state_ff <= bridge_sideband_pkg::RD_SAMPLE;
				bridge_sideband_pkg::RD_SAMPLE:
					rd_state_ff <= bridge_sideband_pkg::RD_ECC_HOLD;
				bridge_sideband_pkg::RD_ECC_HOLD:
					rd_state_ff <= mem_read_req ? bridge_sideband_pkg::RD_SAMPLE
						: bridge_sideband_pkg::RD_IDLE;
				default:
					rd_state_ff <= bridge_sideband_pkg::RD_IDLE;
			endcase
		end
	end
	assign mem_read_sample =
		(rd_state_ff == bridge_sideband_pkg::RD_SAMPLE);
	// Open spans the sample and the cycle after, so it falls after the sample
	assign proc_read_latch_open = mem_read_sample
		| (rd_state_ff == bridge_sideband_pkg::RD_ECC_HOLD)
		| pci_read_req;

	// Burst read mask after the first sample until the read latch drains
	logic mask_ff;
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			mask_ff <= 1'b0;
		else if (!pci_burst_read || (mask_ff && pci_read_latch_empty))
			mask_ff <= 1'b0;
		else if (mem_read_sample)
			mask_ff <= 1'b1;
	end
	assign read_sample_mask = mask_ff;
	// Shared line: all-ones, ROM location under byte load, or mask
	assign ones_romloc_mask_select = rom_byte_valid ? rom_remote
		: (all_ones_req | mask_ff);

	// Datapath latches in the buffer chip
	logic [DATA_W-1:0] read_latch_ff;
	assign proc_to_pci_wlatch_open = proc_write_open_req;
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			wlatch_out <= '0;
			read_latch_ff <= '0;
			pci_read_latch_out <= '0;
		end
		else
		begin
			if (proc_to_pci_wlatch_open)
				wlatch_out <= proc_data_in;
			if (proc_read_latch_open)
				read_latch_ff <= mem_data_in;
			if (mem_read_sample)
				pci_read_latch_out <= mem_data_in;
		end
	end

	// Output drive starts one clock after the enable; all-ones overrides except during ROM byte load
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			proc_data_drive <= 1'b0;
			proc_data_out <= '0;
		end
		else
		begin
			proc_data_drive <= ~proc_data_oe_n;
			if (all_ones_req && !rom_byte_valid)
				proc_data_out <= '1;
			else if (rom_word_valid)
				proc_data_out <= rom_word_out;
			else
				proc_data_out <= read_latch_ff;
		end
	end

	// Even byte parity check on processor writes
	logic [7:0] lane_bad;
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_par
			assign lane_bad[g] = ^{proc_data_in[g*8 +: 8], proc_parity_in[g]};
		end
	endgenerate
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			proc_bus_parity_fault_n <= 1'b1;
		else
			proc_bus_parity_fault_n <= ~(proc_write_cycle && |lane_bad);
	end
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			par_seen_ff <= 1'b0;
		else if (proc_write_cycle && |lane_bad)
			par_seen_ff <= 1'b1;
		else if (ctrl_ff[`CTRL_NMI_CLR_BIT])
			par_seen_ff <= 1'b0;
	end

	// AXI4-Lite write path: address and data taken in either order
	logic aw_have_ff;
	logic w_have_ff;
	logic [11:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	assign s_axi_awready = ~aw_have_ff & ~s_axi_bvalid;
	assign s_axi_wready = ~w_have_ff & ~s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (aw_have_ff && w_have_ff)
			begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_ff == `REG_CTRL_OFF) ? `RESP_OKAY
					: `RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Control register with byte strobes; clear bit self-clears
	logic wr_ctrl;
	assign wr_ctrl = aw_have_ff & w_have_ff & (aw_addr_ff == `REG_CTRL_OFF);
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			ctrl_ff <= `CTRL_RESET;
		else
		begin
			ctrl_ff[`CTRL_NMI_CLR_BIT] <= 1'b0;
			if (wr_ctrl)
			begin
				for (int b = 0; b < 4; b++)
					if (w_strb_ff[b])
						ctrl_ff[b*8 +: 8] <= w_data_ff[b*8 +: 8];
			end
		end
	end

	// AXI4-Lite read path, one cycle to answer
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			unique case (s_axi_araddr)
				`REG_CTRL_OFF: s_axi_rdata <= ctrl_ff;
				`REG_STATUS_OFF: s_axi_rdata <= {26'h0, strap_ff,
					(rom_cnt_ff == 3'h0), wlock_ff, ~proc_irq_out_n,
					par_seen_ff, nmi_seen_ff};
				`REG_SAMPLE_OFF: s_axi_rdata <= {29'h0, rd_state_ff};
				`REG_ROMLO_OFF: s_axi_rdata <= rom_word_out[31:0];
				`REG_ROMHI_OFF: s_axi_rdata <= rom_word_out[63:32];
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule
`default_nettype wire

// file: bridge_ctl_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_ctl_checker (
	// Clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_on_reset_n,
	// Watched ports
	input wire logic irq_request_in,
	input wire logic proc_irq_out_n,
	input wire logic nonmaskable_request_in,
	input wire logic proc_error_out,
	input wire logic rom_read_req,
	input wire logic rom_oe_n,
	input wire logic proc_write_open_req,
	input wire logic proc_to_pci_wlatch_open,
	input wire logic mem_read_req,
	input wire logic mem_read_sample,
	input wire logic proc_read_latch_open,
	input wire logic proc_data_oe_n,
	input wire logic proc_data_drive,
	input wire logic [63:0] proc_data_in,
	input wire logic [63:0] wlatch_out
);
	// One clock domain; either reset returns the logic to its initial state
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !power_on_reset_n);
	// Synchroniser depth bounds how late the interrupt may follow
	irq_assert_a: assert property (
		irq_request_in [*4] |-> !proc_irq_out_n)
		else $error("interrupt output missing");
	irq_release_a: assert property (
		!irq_request_in [*4] |-> proc_irq_out_n)
		else $error("interrupt output stuck");
	rom_strobe_a: assert property (
		!rom_oe_n |-> $past(rom_read_req))
		else $error("rom enable without request");
	// The latch must take the word present while open, not only see the open
	wlatch_open_a: assert property (
		proc_to_pci_wlatch_open |=> wlatch_out == $past(proc_data_in))
		else $error("write latch missed its data");
	wlatch_hold_a: assert property (
		!proc_to_pci_wlatch_open |=> $stable(wlatch_out))
		else $error("write latch changed while closed");
	sample_pulse_a: assert property (
		mem_read_sample |=> !mem_read_sample)
		else $error("sample wider than one cycle");
	open_extend_a: assert property (
		mem_read_sample |-> proc_read_latch_open ##1 proc_read_latch_open)
		else $error("read latch closed too early");
	sample_cause_a: assert property (
		mem_read_sample |-> $past(mem_read_req))
		else $error("sample without request");
	drive_delay_a: assert property (
		!proc_data_oe_n |=> proc_data_drive)
		else $error("data bus not driven");
	error_report_a: assert property (
		nonmaskable_request_in [*3] |-> ##[0:2] proc_error_out)
		else $error("error not reported");
	// Main scenarios reached
	cover property (mem_read_sample ##1 proc_read_latch_open);
	cover property (!proc_irq_out_n);
	cover property ($rose(proc_error_out));
endmodule
bind bridge_sideband_and_datapath_ctl bridge_ctl_checker i_chk (.aclk,
	.aresetn, .power_on_reset_n, .irq_request_in, .proc_irq_out_n,
	.nonmaskable_request_in, .proc_error_out, .rom_read_req, .rom_oe_n,
	.proc_write_open_req, .proc_to_pci_wlatch_open, .mem_read_req,
	.mem_read_sample, .proc_read_latch_open, .proc_data_oe_n,
	.proc_data_drive, .proc_data_in, .wlatch_out);
`default_nettype wire

// file: host_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
	// Clock
	input wire logic aclk,
	// Bus grants, active low
	input wire logic [1:0] grant_n,
	// Processor interrupt side
	input wire logic proc_irq_in_n,
	input wire logic external_irq_enable_bit,
	// Toward the bridge and the bench
	output logic ignore_high_addr_bit,
	output logic irq_taken
);
	// Registered, so the level is settled a clock before any address phase
	always_ff @(posedge aclk)
	begin
		ignore_high_addr_bit <= &grant_n;
	end
	// Level sensitive, not latched: drops as soon as the line releases
	assign irq_taken = !proc_irq_in_n && external_irq_enable_bit;
endmodule
`default_nettype wire

// file: tb_bridge_sideband_and_datapath_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_sideband_and_datapath_ctl;
	logic aclk = 0, aresetn = 0, power_on_reset_n = 0, clock_mode_strap = 0;
	logic pci_addr_phase = 0, irq_request_in = 0, nonmaskable_request_in = 0;
	logic rom_read_req = 0, rom_write_req = 0, rom_byte_valid = 0;
	logic all_ones_req = 0, pci_burst_read = 0, pci_read_latch_empty = 0;
	logic mem_read_req = 0, pci_read_req = 0, proc_write_open_req = 0;
	logic proc_data_oe_n = 1, proc_write_cycle = 0, irq_en = 0, irq_taken;
	logic [1:0] grant_n = 0;
	logic [7:0] rom_byte_in = 0, proc_parity_in = 0;
	logic [31:0] pci_addr_in = 0, mem_addr_out;
	logic [63:0] proc_data_in = 0, mem_data_in = 0, exp;
	logic [63:0] rom_word_out, proc_data_out, pci_read_latch_out, wlatch_out;
	logic proc_irq_out_n, proc_error_out, rom_oe_n, rom_we_n, rom_word_valid;
	logic proc_data_drive, ones_romloc_mask_select, read_sample_mask;
	logic mem_read_sample, proc_to_pci_wlatch_open, proc_read_latch_open;
	logic proc_bus_parity_fault_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic ignore_high_addr_bit;
	int miscompares = 0, checked = 0;

	// 100 MHz clock
	always #5 aclk = ~aclk;

	bridge_sideband_and_datapath_ctl i_dut (.aclk, .aresetn, .power_on_reset_n,
		.clock_mode_strap, .ignore_high_addr_bit, .pci_addr_phase, .pci_addr_in,
		.mem_addr_out, .irq_request_in, .nonmaskable_request_in, .proc_irq_out_n,
		.proc_error_out, .rom_read_req, .rom_write_req, .rom_byte_valid,
		.rom_byte_in, .rom_oe_n, .rom_we_n, .rom_word_out, .rom_word_valid,
		.all_ones_req, .pci_burst_read, .pci_read_latch_empty, .mem_read_req,
		.pci_read_req, .proc_write_open_req, .proc_data_oe_n, .proc_data_in,
		.proc_parity_in, .proc_write_cycle, .proc_data_out, .proc_data_drive,
		.mem_data_in, .ones_romloc_mask_select, .read_sample_mask,
		.mem_read_sample, .proc_to_pci_wlatch_open, .proc_read_latch_open,
		.proc_bus_parity_fault_n, .pci_read_latch_out, .wlatch_out,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	host_side_model i_host (.aclk, .grant_n, .proc_irq_in_n(proc_irq_out_n),
		.external_irq_enable_bit(irq_en), .ignore_high_addr_bit, .irq_taken);

	// Compare and count
	task chk(input logic [63:0] got, input logic [63:0] want);
		checked++;
		if (got !== want)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task chk1(input logic got, input logic want);
		chk({63'h0, got}, {63'h0, want});
	endtask

	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Register write; each channel released once taken
	task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(64'(s_axi_bresp), 64'(r));
	endtask

	task axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(64'(s_axi_rdata), 64'(d));
		chk(64'(s_axi_rresp), 64'(r));
	endtask

	// One address phase, then the latched result
	task remap(input logic [1:0] g, input logic [31:0] want);
		@(posedge aclk);
		grant_n <= g;
		pci_addr_in <= 32'hFF12_3456;
		tick(2);
		pci_addr_phase <= 1'b1;
		tick(1);
		pci_addr_phase <= 1'b0;
		tick(2);
		chk(64'(mem_addr_out), 64'(want));
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Test sequence
	initial
	begin
		tick(20);
		// Power-on reset at start too, so the strap is captured before use
		aresetn <= 1'b1;
		power_on_reset_n <= 1'b1;
		tick(1);
		axr(12'h000, 32'h0000_0000, 2'h0);
		axr(12'h004, 32'h0000_0010, 2'h0);
		axr(12'h0FC, 32'h0000_0000, 2'h2);
		axw(12'h004, 32'h0000_0001, 2'h2);
		$display("register test done");
		remap(2'b11, 32'h0012_3456);
		remap(2'b01, 32'hFF12_3456);
		$display("remap test done");
		irq_request_in <= 1'b1;
		tick(5);
		chk1(proc_irq_out_n, 1'b0);
		chk1(irq_taken, 1'b0);
		irq_en <= 1'b1;
		tick(2);
		chk1(irq_taken, 1'b1);
		irq_request_in <= 1'b0;
		tick(5);
		chk1(proc_irq_out_n, 1'b1);
		nonmaskable_request_in <= 1'b1;
		tick(5);
		nonmaskable_request_in <= 1'b0;
		chk1(proc_error_out, 1'b1);
		$display("interrupt test done");
		for (int k = 0; k < 8; k++)
		begin
			exp[8*k +: 8] = 8'(k + 1);
			@(posedge aclk);
			rom_byte_valid <= 1'b1;
			rom_byte_in <= 8'(k + 1);
			tick(1);
			rom_byte_valid <= 1'b0;
		end
		tick(1);
		chk1(rom_word_valid, 1'b1);
		chk(rom_word_out, exp);
		rom_read_req <= 1'b1;
		rom_write_req <= 1'b1;
		tick(3);
		chk1(rom_oe_n, 1'b0);
		chk1(rom_we_n, 1'b0);
		axw(12'h000, 32'h0000_0001, 2'h0);
		rom_byte_valid <= 1'b1;
		tick(3);
		chk1(ones_romloc_mask_select, 1'b1);
		chk1(rom_oe_n, 1'b1);
		chk1(rom_we_n, 1'b1);
		rom_byte_valid <= 1'b0;
		rom_read_req <= 1'b0;
		rom_write_req <= 1'b0;
		$display("rom test done");
		proc_write_cycle <= 1'b1;
		proc_data_in <= 64'h0000_0000_0000_0001;
		tick(1);
		proc_write_cycle <= 1'b0;
		tick(1);
		chk1(proc_bus_parity_fault_n, 1'b0);
		all_ones_req <= 1'b1;
		proc_data_oe_n <= 1'b0;
		proc_write_cycle <= 1'b1;
		proc_write_open_req <= 1'b1;
		proc_data_in <= 64'hA5A5_A5A5_A5A5_A5A5;
		tick(1);
		proc_write_open_req <= 1'b0;
		proc_data_in <= 64'h0000_0000_0000_0003;
		tick(2);
		chk(proc_data_out, 64'hFFFF_FFFF_FFFF_FFFF);
		chk1(proc_data_drive, 1'b1);
		chk(wlatch_out, 64'hA5A5_A5A5_A5A5_A5A5);
		chk1(proc_bus_parity_fault_n, 1'b1);
		proc_write_cycle <= 1'b0;
		all_ones_req <= 1'b0;
		proc_data_oe_n <= 1'b1;
		$display("datapath test done");
		pci_burst_read <= 1'b1;
		mem_data_in <= 64'h1234_5678_9ABC_DEF0;
		mem_read_req <= 1'b1;
		tick(1);
		mem_read_req <= 1'b0;
		tick(1);
		chk1(mem_read_sample, 1'b1);
		chk1(proc_read_latch_open, 1'b1);
		tick(1);
		chk1(proc_read_latch_open, 1'b1);
		chk(pci_read_latch_out, 64'h1234_5678_9ABC_DEF0);
		chk1(read_sample_mask, 1'b1);
		pci_read_latch_empty <= 1'b1;
		tick(2);
		chk1(read_sample_mask, 1'b0);
		pci_burst_read <= 1'b0;
		// PCI data opens the read latch; closed, it holds
		mem_data_in <= 64'h0F0F_0F0F_0F0F_0F0F;
		pci_read_req <= 1'b1;
		tick(1);
		chk1(proc_read_latch_open, 1'b1);
		pci_read_req <= 1'b0;
		mem_data_in <= 64'h0000_0000_0000_0000;
		tick(2);
		chk(proc_data_out, 64'h0F0F_0F0F_0F0F_0F0F);
		$display("read sample test done");
		axw(12'h000, 32'h0000_0004, 2'h0);
		axr(12'h004, 32'h0000_000B, 2'h0);
		clock_mode_strap <= 1'b1;
		power_on_reset_n <= 1'b0;
		tick(3);
		power_on_reset_n <= 1'b1;
		clock_mode_strap <= 1'b0;
		tick(1);
		axr(12'h004, 32'h0000_0030, 2'h0);
		chk1(proc_error_out, 1'b0);
		$display("power-on test done");
		complete_run;
	end

	// Watchdog, far beyond the expected run length
	initial
	begin
		#200000;
		miscompares++;
		complete_run;
	end
endmodule
`default_nettype wire
